/* rtl/hie_event_flags.sv */
/*
 Sticky event flags with write-one-to-clear, an enable mask and one level interrupt output.
 Assumes one clock and a synchronised active-low reset.
*/
`timescale 1ns/1ps
`include "hie_regs.svh"

module hie_event_flags (
   input  wire logic            mclk,
   input  wire logic            rst_n,
   input  wire hie_pkg::hie_evt_t event_in,
   input  wire logic            clr_we,
   input  wire logic            ena_we,
   input  wire hie_pkg::hie_evt_t wdata,
   output hie_pkg::hie_evt_t    status_r,
   output hie_pkg::hie_evt_t    enable_r,
   output logic                 irq_r
);

   genvar i;

   generate
      for (i = 0; i < 4; i++) begin : g_flag
         // A set in the same cycle as a clear wins, so no event is lost.
         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               status_r[i] <= 1'b0;
            end else if (event_in[i]) begin
               status_r[i] <= 1'b1;
            end else if (clr_we && wdata[i]) begin
               status_r[i] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         enable_r <= `HIE_EVT_RESET;
      end else if (ena_we) begin
         enable_r <= wdata;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(status_r & enable_r);
      end
   end

endmodule : hie_event_flags

/* rtl/hie_host_irq_enable.sv */
/*
 Host interrupt enable register with its set view and clear view, reached over APB.
 Assumes the internal status bits arrive synchronous to mclk from the surrounding peripheral.
*/
`timescale 1ns/1ps
`include "hie_regs.svh"

module hie_host_irq_enable (
   input  wire logic              mclk,
   input  wire logic              resetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   input  wire hie_pkg::hie_word_t int_status,
   output hie_pkg::hie_word_t     prdata,
   output logic                   pready,
   output logic                   pslverr,
   output hie_pkg::hie_word_t     host_irq_enable,
   output logic                   irq
);

   logic                   rst_meta_r;
   logic                   rst_n;
   hie_pkg::hie_apb_state_t state_r;
   hie_pkg::hie_word_t     enable_r;
   hie_pkg::hie_word_t     set_view;
   hie_pkg::hie_word_t     clr_view;
   hie_pkg::hie_word_t     rdata_nxt;
   logic                   decode_ok;
   logic                   wr_take;
   logic                   rd_take;
   logic                   wr_set;
   logic                   wr_clr;
   logic                   wr_evt_clr;
   logic                   wr_evt_ena;
   logic                   bad_addr;
   hie_pkg::hie_evt_t      evt_in;
   hie_pkg::hie_evt_t      evt_status;
   hie_pkg::hie_evt_t      evt_enable;
   logic                   evt_irq;
   logic                   src_pending_r;
   hie_pkg::hie_word_t     wmask;

   // Reset is released through two flip-flops; only the second feeds logic.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_r <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n      <= rst_meta_r;
      end
   end

   // Byte strobes select which lanes of a set or clear view write take effect.
   assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

   // Readback views are masked to the defined bits only.
   assign set_view = enable_r & `HIE_DEFINED_MASK;
   assign clr_view = enable_r & int_status & `HIE_DEFINED_MASK;

   always_comb begin
      decode_ok = 1'b1;
      rdata_nxt = 32'h0000_0000;
      if (paddr == `HIE_OFF_SET_VIEW) begin
         rdata_nxt = set_view;
      end else if (paddr == `HIE_OFF_CLR_VIEW) begin
         rdata_nxt = clr_view;
      end else if (paddr == `HIE_OFF_EVT_STATUS) begin
         rdata_nxt = {28'h000_0000, evt_status};
      end else if (paddr == `HIE_OFF_EVT_CLEAR) begin
         rdata_nxt = 32'h0000_0000;
      end else if (paddr == `HIE_OFF_EVT_ENABLE) begin
         rdata_nxt = {28'h000_0000, evt_enable};
      end else if (paddr == `HIE_OFF_IRQ_STATUS) begin
         rdata_nxt = {31'h0000_0000, |clr_view};
      end else begin
         decode_ok = 1'b0;
      end
   end

   // Every access takes one wait state: setup, access, then pready.
   assign wr_take    = (state_r == hie_pkg::HIE_ACCESS) && psel && penable && pwrite && decode_ok;
   assign rd_take    = (state_r == hie_pkg::HIE_ACCESS) && psel && penable && !pwrite;
   assign wr_set     = wr_take && (paddr == `HIE_OFF_SET_VIEW);
   assign wr_clr     = wr_take && (paddr == `HIE_OFF_CLR_VIEW);
   assign wr_evt_clr = wr_take && (paddr == `HIE_OFF_EVT_CLEAR);
   assign wr_evt_ena = wr_take && (paddr == `HIE_OFF_EVT_ENABLE);
   assign bad_addr   = (state_r == hie_pkg::HIE_ACCESS) && psel && penable && !decode_ok;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= hie_pkg::HIE_IDLE;
      end else begin
         case (state_r)
            hie_pkg::HIE_IDLE: begin
               if (psel && penable) begin
                  state_r <= hie_pkg::HIE_ACCESS;
               end
            end
            hie_pkg::HIE_ACCESS: begin
               state_r <= hie_pkg::HIE_IDLE;
            end
            default: begin
               state_r <= hie_pkg::HIE_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= (state_r == hie_pkg::HIE_IDLE) && psel && penable;
         pslverr <= (state_r == hie_pkg::HIE_IDLE) && psel && penable && !decode_ok;
         prdata  <= ((state_r == hie_pkg::HIE_IDLE) && psel && penable && !pwrite) ? rdata_nxt : 32'h0000_0000;
      end
   end

   // Set and clear in the same word cannot happen: they are distinct addresses.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         enable_r <= `HIE_ENABLE_RESET;
      end else if (wr_set) begin
         enable_r <= enable_r | (pwdata & wmask & `HIE_DEFINED_MASK);
      end else if (wr_clr) begin
         enable_r <= enable_r & ~(pwdata & wmask & `HIE_DEFINED_MASK);
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         host_irq_enable <= `HIE_ENABLE_RESET;
      end else begin
         host_irq_enable <= enable_r;
      end
   end

   // A source event fires when the masked view first becomes nonzero.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         src_pending_r <= 1'b0;
      end else begin
         src_pending_r <= |clr_view;
      end
   end

   always_comb begin
      evt_in                        = `HIE_EVT_RESET;
      evt_in[`HIE_EVT_POS_SET]      = wr_set;
      evt_in[`HIE_EVT_POS_CLR]      = wr_clr;
      evt_in[`HIE_EVT_POS_SRC]      = (|clr_view) && !src_pending_r;
      evt_in[`HIE_EVT_POS_BADADDR]  = bad_addr;
   end

   hie_event_flags u_flags (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .event_in (evt_in),
      .clr_we   (wr_evt_clr),
      .ena_we   (wr_evt_ena),
      .wdata    (pwdata[3:0]),
      .status_r (evt_status),
      .enable_r (evt_enable),
      .irq_r    (evt_irq)
   );

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= evt_irq;
      end
   end

   property p_set_reads_enable;
      @(posedge mclk) disable iff (!rst_n)
      (state_r == hie_pkg::HIE_IDLE && psel && penable && !pwrite && paddr == `HIE_OFF_SET_VIEW)
      |=> (prdata == $past(enable_r & `HIE_DEFINED_MASK));
   endproperty
   a_set_reads_enable: assert property (p_set_reads_enable) else $error("set view read mismatch");

   property p_set_parity;
      @(posedge mclk) disable iff (!rst_n)
      (pready && !pwrite && paddr == `HIE_OFF_SET_VIEW) |-> prdata[6] == enable_r[6];
   endproperty
   a_set_parity: assert property (p_set_parity) else $error("parity enable readback wrong");

   property p_set_syserr;
      @(posedge mclk) disable iff (!rst_n)
      (pready && !pwrite && paddr == `HIE_OFF_SET_VIEW) |-> prdata[5] == enable_r[5];
   endproperty
   a_set_syserr: assert property (p_set_syserr) else $error("system error enable readback wrong");

   property p_set_aborts;
      @(posedge mclk) disable iff (!rst_n)
      (pready && !pwrite && paddr == `HIE_OFF_SET_VIEW) |-> prdata[2:1] == enable_r[2:1];
   endproperty
   a_set_aborts: assert property (p_set_aborts) else $error("abort enable readback wrong");

   property p_clr_masked;
      @(posedge mclk) disable iff (!rst_n)
      (state_r == hie_pkg::HIE_IDLE && psel && penable && !pwrite && paddr == `HIE_OFF_CLR_VIEW)
      |=> (prdata == $past(enable_r & int_status & `HIE_DEFINED_MASK));
   endproperty
   a_clr_masked: assert property (p_clr_masked) else $error("clear view read not masked");

   sequence s_set_write;
      wr_set ##1 1'b1;
   endsequence

   property p_set_write;
      @(posedge mclk) disable iff (!rst_n)
      wr_set |=> ((enable_r & $past(pwdata & wmask & `HIE_DEFINED_MASK)) == $past(pwdata & wmask & `HIE_DEFINED_MASK))
      && ((enable_r & ~$past(pwdata & wmask)) == ($past(enable_r) & ~$past(pwdata & wmask)));
   endproperty
   a_set_write: assert property (p_set_write) else $error("set view write wrong");

   property p_clr_write;
      @(posedge mclk) disable iff (!rst_n)
      wr_clr |=> ((enable_r & $past(pwdata & wmask)) == 32'h0000_0000);
   endproperty
   a_clr_write: assert property (p_clr_write) else $error("clear view write wrong");

   property p_reserved_zero;
      @(posedge mclk) disable iff (!rst_n)
      (enable_r & ~`HIE_DEFINED_MASK) == 32'h0000_0000;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved enable bit set");

   property p_reset_clear;
      @(posedge mclk) $rose(rst_n) |-> enable_r == 32'h0000_0000;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("enable not cleared by reset");

   sequence s_access_start;
      (state_r == hie_pkg::HIE_IDLE) && psel && penable;
   endsequence

   sequence s_ready_pulse;
      pready ##1 !pready;
   endsequence

   property p_ready_one_wait;
      @(posedge mclk) disable iff (!rst_n)
      s_access_start |=> s_ready_pulse;
   endproperty
   a_ready_one_wait: assert property (p_ready_one_wait) else $error("access did not end after one wait state");

   property p_read_data_quiet;
      @(posedge mclk) disable iff (!rst_n)
      !pready |-> prdata == 32'h0000_0000;
   endproperty
   a_read_data_quiet: assert property (p_read_data_quiet) else $error("read data shown outside an answer");

   property p_read_answer;
      @(posedge mclk) disable iff (!rst_n)
      rd_take |-> pready;
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("read taken without ready");

   property p_error_only_answer;
      @(posedge mclk) disable iff (!rst_n)
      pslverr |-> pready;
   endproperty
   a_error_only_answer: assert property (p_error_only_answer) else $error("error shown without ready");

   property p_state_returns;
      @(posedge mclk) disable iff (!rst_n)
      (state_r == hie_pkg::HIE_ACCESS) |=> (state_r == hie_pkg::HIE_IDLE);
   endproperty
   a_state_returns: assert property (p_state_returns) else $error("access state held too long");

   property p_unmapped_write_ignored;
      @(posedge mclk) disable iff (!rst_n)
      (bad_addr && pwrite) |=> $stable(enable_r);
   endproperty
   a_unmapped_write_ignored: assert property (p_unmapped_write_ignored) else $error("unmapped write changed enable");

   property p_mirror;
      @(posedge mclk) disable iff (!rst_n)
      host_irq_enable == $past(enable_r);
   endproperty
   a_mirror: assert property (p_mirror) else $error("enable copy does not follow the register");

   property p_irq_follows;
      @(posedge mclk) disable iff (!rst_n)
      irq == $past(evt_irq);
   endproperty
   a_irq_follows: assert property (p_irq_follows) else $error("interrupt output does not follow the flags");

   property p_view_reserved;
      @(posedge mclk) disable iff (!rst_n)
      (pready && !pwrite && (paddr == `HIE_OFF_SET_VIEW || paddr == `HIE_OFF_CLR_VIEW))
      |-> (prdata & ~`HIE_DEFINED_MASK) == 32'h0000_0000;
   endproperty
   a_view_reserved: assert property (p_view_reserved) else $error("reserved view bit read as one");

   sequence s_read_clr_view;
      (state_r == hie_pkg::HIE_IDLE) && psel && penable && !pwrite && (paddr == `HIE_OFF_CLR_VIEW);
   endsequence

   property p_clr_soft;
      @(posedge mclk) disable iff (!rst_n)
      s_read_clr_view |=> prdata[27:24] == $past(enable_r[27:24] & int_status[27:24]);
   endproperty
   a_clr_soft: assert property (p_clr_soft) else $error("software bits of clear view wrong");

   property p_clr_parity;
      @(posedge mclk) disable iff (!rst_n)
      s_read_clr_view |=> prdata[6] == $past(enable_r[6] & int_status[6]);
   endproperty
   a_clr_parity: assert property (p_clr_parity) else $error("parity bit of clear view wrong");

   property p_clr_syserr;
      @(posedge mclk) disable iff (!rst_n)
      s_read_clr_view |=> prdata[5] == $past(enable_r[5] & int_status[5]);
   endproperty
   a_clr_syserr: assert property (p_clr_syserr) else $error("system error bit of clear view wrong");

   property p_clr_aborts;
      @(posedge mclk) disable iff (!rst_n)
      s_read_clr_view |=> prdata[2:1] == $past(enable_r[2:1] & int_status[2:1]);
   endproperty
   a_clr_aborts: assert property (p_clr_aborts) else $error("abort bits of clear view wrong");

endmodule : hie_host_irq_enable

/* rtl/hie_pkg.sv */
/*
 Types shared by the host interrupt enable readback block.
 Assumes hie_regs.svh supplies the numeric constants.
*/
package hie_pkg;

   typedef logic [31:0] hie_word_t;
   typedef logic [3:0]  hie_evt_t;

   typedef enum logic [1:0] {
      HIE_IDLE,
      HIE_ACCESS
   } hie_apb_state_t;

endpackage : hie_pkg

/* rtl/hie_regs.svh */
/*
 Register offsets, field positions, reset values and masks of the host interrupt enable readback block.
 Assumes a 32-bit APB register bus with one aligned word per register.
*/
`ifndef HIE_REGS_SVH
`define HIE_REGS_SVH

`define HIE_OFF_SET_VIEW     12'h000
`define HIE_OFF_CLR_VIEW     12'h004
`define HIE_OFF_EVT_STATUS   12'h008
`define HIE_OFF_EVT_CLEAR    12'h00c
`define HIE_OFF_EVT_ENABLE   12'h010
`define HIE_OFF_IRQ_STATUS   12'h014

`define HIE_POS_SOFT_LO      24
`define HIE_POS_SOFT_HI      27
`define HIE_POS_PARITY       6
`define HIE_POS_SYSERR       5
`define HIE_POS_MABORT       2
`define HIE_POS_TABORT       1

`define HIE_DEFINED_MASK     32'h0f00_0066
`define HIE_ENABLE_RESET     32'h0000_0000
`define HIE_EVT_RESET        4'h0
`define HIE_EVT_MASK         32'h0000_000f
`define HIE_EVT_POS_SET      0
`define HIE_EVT_POS_CLR      1
`define HIE_EVT_POS_SRC      2
`define HIE_EVT_POS_BADADDR  3

`endif

/* verif/hie_host_irq_enable_tb.sv */
/*
 Self-checking bench for the host interrupt enable set and clear views, driven as an APB master.
 Assumes the event block decodes at 0x008 to 0x010 and that irq follows its cause within two cycles.
*/
`timescale 1ns/1ps

module hie_host_irq_enable_tb;

   logic               mclk;
   logic               resetn;
   logic               psel;
   logic               penable;
   logic               pwrite;
   logic [11:0]        paddr;
   logic [31:0]        pwdata;
   logic [3:0]         pstrb;
   hie_pkg::hie_word_t int_status;
   hie_pkg::hie_word_t prdata;
   logic               pready;
   logic               pslverr;
   hie_pkg::hie_word_t host_irq_enable;
   logic               irq;
   hie_pkg::hie_word_t rd;
   logic               err;
   int                 bad_count = 0;
   int                 checks_done = 0;
   int                 cycles = 0;
   // Columns: set view write, clear view write, status, set view read, clear view read.
   hie_pkg::hie_word_t rows [0:4][0:4] = '{
      '{32'hffff_ffff, 32'h0000_0000, 32'hffff_ffff, 32'h0f00_0066, 32'h0f00_0066},
      '{32'h0f00_0066, 32'h0a00_0042, 32'hffff_ffff, 32'h0500_0024, 32'h0500_0024},
      '{32'h0f00_0066, 32'h0000_0000, 32'h0a00_0042, 32'h0f00_0066, 32'h0a00_0042},
      '{32'h0500_0024, 32'h0000_0000, 32'h0300_0006, 32'h0500_0024, 32'h0100_0004},
      '{32'hf0ff_ff99, 32'h0000_0000, 32'hffff_ffff, 32'h0000_0000, 32'h0000_0000}};

   hie_host_irq_enable uut (
      .mclk            (mclk),
      .resetn          (resetn),
      .psel            (psel),
      .penable         (penable),
      .pwrite          (pwrite),
      .paddr           (paddr),
      .pwdata          (pwdata),
      .pstrb           (pstrb),
      .int_status      (int_status),
      .prdata          (prdata),
      .pready          (pready),
      .pslverr         (pslverr),
      .host_irq_enable (host_irq_enable),
      .irq             (irq)
   );

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : finish_test

   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         bad_count++;
         finish_test();
      end
   end

   task automatic chk(input hie_pkg::hie_word_t got, input hie_pkg::hie_word_t exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer; the request is held until pready is sampled high.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask : apb

   task automatic do_reset();
      resetn <= 1'b0;
      repeat (12) @(posedge mclk);
      resetn <= 1'b1;
      repeat (3) @(posedge mclk);
   endtask : do_reset

   task automatic irq_is(input logic exp);
      repeat (2) @(posedge mclk);
      chk({31'h0, irq}, {31'h0, exp});
   endtask : irq_is

   initial begin
      resetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'hf;
      int_status = 32'hffff_ffff;
      do_reset();
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h0);
      $display("test reset done");
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, 12'h004, 32'hffff_ffff);
         apb(1'b1, 12'h000, rows[i][0]);
         apb(1'b1, 12'h004, rows[i][1]);
         int_status <= rows[i][2];
         apb(1'b0, 12'h000, 32'h0);
         chk(rd, rows[i][3]);
         apb(1'b0, 12'h004, 32'h0);
         chk(rd, rows[i][4]);
         chk(host_irq_enable, rows[i][3]);
      end
      $display("test rows done");
      // A write with the top byte lane off must leave the software enables alone.
      apb(1'b1, 12'h004, 32'hffff_ffff);
      pstrb <= 4'h7;
      apb(1'b1, 12'h000, 32'h0f00_0066);
      pstrb <= 4'hf;
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h0000_0066);
      $display("test strobe done");
      apb(1'b1, 12'h00c, 32'h0000_000f);
      apb(1'b1, 12'h010, 32'h0000_0008);
      irq_is(1'b0);
      apb(1'b1, 12'h040, 32'h0f00_0066);
      chk({31'h0, err}, 32'h1);
      apb(1'b0, 12'h040, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, err}, 32'h1);
      irq_is(1'b1);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h0000_0008);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h0000_0066);
      apb(1'b1, 12'h010, 32'h0);
      irq_is(1'b0);
      apb(1'b1, 12'h010, 32'h0000_0008);
      irq_is(1'b1);
      apb(1'b1, 12'h00c, 32'h0000_0008);
      irq_is(1'b0);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd & 32'h8, 32'h0);
      $display("test events done");
      apb(1'b1, 12'h004, 32'hffff_ffff);
      apb(1'b1, 12'h00c, 32'h0000_000f);
      apb(1'b1, 12'h000, 32'h0000_0000);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h0000_0001);
      apb(1'b0, 12'h014, 32'h0);
      chk(rd, 32'h0000_0000);
      apb(1'b1, 12'h004, 32'h0000_0000);
      apb(1'b1, 12'h000, 32'h0000_0066);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h0000_0007);
      apb(1'b0, 12'h014, 32'h0);
      chk(rd, 32'h0000_0001);
      $display("test event sources done");
      do_reset();
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h0);
      chk(host_irq_enable, 32'h0);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h0000_0000);
      chk({31'h0, irq}, 32'h0);
      $display("test second reset done");
      finish_test();
   end

endmodule : hie_host_irq_enable_tb
